/* pkg/gpp_regs.svh */
// register offsets, field positions, masks and reset values of the gauge port pin control block
//------------------------------------------------------------------------------
// Summary of operation
// - port 0 eight bits, inputs after reset
// - each bidirectional bit has own direction
// - input bits may enable on-chip pull-up, except on ports 2 and 6
// - port 1 bits 0-4 select TTL input
// - port 1 bits 0-6 select open-drain
// - port 6 four bits, all open-drain capable
// - port 2 four bits, analog after reset
// - per-bit analog select picks digital or analog
// - port 12 three input-only bits
// - port 13 input-only bit, also interrupt
// - system reset input is active low
// - front-end reset output, active low
// - front-end interrupts fed internally, not pins
// - debug tool line sampled at reset release
// - redirect register moves serial input pin
// - bridge uses driven clock, four data lines
//------------------------------------------------------------------------------
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH

// number of bidirectional ports: slots 0..6 are ports 0,1,2,3,4,6,7
`define GPP_NPORT          7

// per-port capability masks, one byte per slot, slot 0 in the low byte
`define GPP_WIDTH_MASK     64'h00FF_0F01_0F0F_7FFF
`define GPP_PULL_MASK      64'h00FF_0001_0F00_7FFF
`define GPP_TTL_MASK       64'h0000_0000_0000_1F18
`define GPP_OD_MASK        64'h0000_0F00_0000_7F18
`define GPP_ANALOG_MASK    64'h0000_0000_000F_0000

// reset values
`define GPP_CFG_RST        8'h00
`define GPP_ANALOG_RST     64'h0000_0000_000F_0000
`define GPP_REDIR_RST      8'h00

// word index of the misc registers (byte address is four times this)
`define GPP_IDX_REDIR      8'h40
`define GPP_IDX_IRQ_STAT   8'h41
`define GPP_IDX_IRQ_EN     8'h42
`define GPP_IDX_IRQ_CLR    8'h43
`define GPP_IDX_MODE       8'h44
`define GPP_IDX_INONLY     8'h45

// field positions
`define GPP_REDIR_SERIAL   0
`define GPP_INONLY_P13     8
`define GPP_IRQ_P13        6
`define GPP_IRQ_W          7
`define GPP_FE_IRQ_W       6

// special pins: bridge clock and redirected serial input
`define GPP_BRIDGE_SLOT    6
`define GPP_BRIDGE_CLK_BIT 3
`define GPP_REDIR_SLOT     5
`define GPP_REDIR_BIT      3

`endif

/* pkg/gpp_pkg.sv */
// types shared by the gauge port pin control block
package gpp_pkg;

   // 32-bit bus word
   typedef logic [31:0] gpp_word_t;

   // one port byte
   typedef logic [7:0] gpp_byte_t;

   // register function selected by word index bits 5:3
   typedef enum logic [2:0] {
      FN_DIR    = 3'h0,  // direction, 1 = output
      FN_OUT    = 3'h1,  // output data
      FN_PULL   = 3'h2,  // pull-up enable
      FN_TTL    = 3'h3,  // ttl input buffer select
      FN_OD     = 3'h4,  // open-drain select
      FN_ANALOG = 3'h5,  // analog select
      FN_INPUT  = 3'h6,  // pin level, read only
      FN_NONE   = 3'h7   // unmapped
   } gpp_func_e;

   // mode sampling at reset release
   typedef enum logic {
      MODE_WAIT = 1'b0,
      MODE_DONE = 1'b1
   } gpp_mode_e;

endpackage

/* logic/gpp_port_ctrl.sv */
// gauge port pin control: port configuration, pin drive, interrupts and wishbone slave
`timescale 1ns/1ps
`include "gpp_regs.svh"

module gpp_port_ctrl #(
   parameter int NPORT = `GPP_NPORT                     // number of bidirectional port slots
) (
   input  wire logic                        clock,           // 20 MHz core clock
   input  wire logic                        rst_b,           // synchronous system reset, low active
   input  wire logic                        clockEn,         // freezes all state outside reset while low
   input  wire logic                        cyc_i,           // wishbone cycle
   input  wire logic                        stb_i,           // wishbone strobe
   input  wire logic                        we_i,            // wishbone write enable
   input  wire logic [9:0]                  adr_i,           // wishbone byte address
   input  wire gpp_pkg::gpp_word_t          dat_i,           // wishbone write data
   input  wire logic [3:0]                  sel_i,           // wishbone byte select
   output      gpp_pkg::gpp_word_t          dat_o,           // wishbone read data
   output      logic                        ack_o,           // wishbone acknowledge
   input  wire logic [NPORT-1:0][7:0]       portPinIn,       // pin levels of bidirectional ports
   output      logic [NPORT-1:0][7:0]       portPinOut,      // pin drive value
   output      logic [NPORT-1:0][7:0]       portPinOe_b,     // pin drive enable, low drives
   output      logic [NPORT-1:0][7:0]       portPullEn,      // on-chip pull-up enable
   output      logic [NPORT-1:0][7:0]       portTtlSel,      // ttl input buffer select
   output      logic [NPORT-1:0][7:0]       portAnalogSel,   // analog input select
   input  wire logic [2:0]                  port12PinIn,     // input-only port 12
   input  wire logic                        port13PinIn,     // input-only port 13, interrupt source
   input  wire logic [`GPP_FE_IRQ_W-1:0]    frontEndIrq,     // internal front-end interrupt requests
   input  wire logic                        supplyFault,     // front-end reset circuit request
   output      logic                        frontEndResetOut_b, // front-end reset output, low active
   input  wire logic                        debugToolLine,   // debug tool line level
   output      logic                        normalMode,      // high when normal operation was chosen
   input  wire logic                        primarySerialIn, // serial input at its primary pin
   output      logic                        serialIn,        // serial input after redirection
   output      logic                        irq              // level interrupt
);
   import gpp_pkg::*;

   //---------------------------------------------------------------------------
   // elaboration checks
   //---------------------------------------------------------------------------
   // the capability masks hold eight slots only
   if (NPORT < 7 || NPORT > 8) begin : g_bad_nport
      $error("NPORT must lie between 7 and 8");
   end

   localparam int MISC_W = 3 + 1 + `GPP_FE_IRQ_W + 1 + 1 + 1;  // width of misc async inputs

   //---------------------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------------------
   // capability mask of one register function for one port slot
   function automatic gpp_byte_t capMask(input gpp_func_e fn, input int slot);
      logic [63:0] m;
      m = 64'h0000_0000_0000_0000;
      unique case (fn)
         FN_DIR, FN_OUT, FN_INPUT : m = `GPP_WIDTH_MASK;
         FN_PULL                  : m = `GPP_PULL_MASK;
         FN_TTL                   : m = `GPP_TTL_MASK;
         FN_OD                    : m = `GPP_OD_MASK;
         FN_ANALOG                : m = `GPP_ANALOG_MASK;
         FN_NONE                  : m = 64'h0000_0000_0000_0000;
      endcase
      return m[slot*8 +: 8];
   endfunction

   //---------------------------------------------------------------------------
   // declarations
   //---------------------------------------------------------------------------
   logic [NPORT-1:0][7:0]     pinMeta;              // first synchroniser stage, pins
   logic [NPORT-1:0][7:0]     pinSync;              // second synchroniser stage, pins
   logic [MISC_W-1:0]         miscMeta;             // first stage, misc inputs
   logic [MISC_W-1:0]         miscSync;             // second stage, misc inputs
   gpp_byte_t                 dirReg   [NPORT];     // direction, 1 = output
   gpp_byte_t                 outReg   [NPORT];     // output data
   gpp_byte_t                 pullReg  [NPORT];     // pull-up enables
   gpp_byte_t                 ttlReg   [NPORT];     // ttl selects
   gpp_byte_t                 odReg    [NPORT];     // open-drain selects
   gpp_byte_t                 anaReg   [NPORT];     // analog selects
   gpp_byte_t                 redirReg;             // pin redirection
   logic [`GPP_IRQ_W-1:0]     irqStat;              // sticky event bits
   logic [`GPP_IRQ_W-1:0]     irqEn;                // event enables
   logic [`GPP_IRQ_W-1:0]     irqPrev;              // previous level for edge detect
   gpp_mode_e                 modeState;            // mode sampling progress
   logic [7:0]                wordIdx;              // word index of access
   gpp_func_e                 accFunc;              // function field of access
   logic [2:0]                accSlot;              // port slot of access
   logic                      cfgArea;              // access falls in port register area
   logic                      slotOk;               // slot exists
   logic                      wrEn;                 // write takes effect this edge
   logic                      rdStart;              // read data is captured this edge
   gpp_word_t                 next_datO;            // read mux result
   logic [2:0]                p12Sync;              // port 12 synchronised
   logic                      p13Sync;              // port 13 synchronised
   logic [`GPP_FE_IRQ_W-1:0]  feIrqSync;            // front-end irqs synchronised
   logic                      faultSync;            // supply fault synchronised
   logic                      toolSync;             // debug tool line synchronised
   logic                      serialSync;           // primary serial input synchronised
   logic [`GPP_IRQ_W-1:0]     irqLevel;             // current levels of event sources
   logic [`GPP_IRQ_W-1:0]     irqEvt;               // rising edges this cycle

   //---------------------------------------------------------------------------
   // input synchronisers
   //---------------------------------------------------------------------------
   // two stages on every pin and every input from the front end; left without
   // reset so that reset has flushed them before the mode line is sampled
   always_ff @(posedge clock) begin
      if (clockEn) begin
         pinMeta  <= portPinIn;
         pinSync  <= pinMeta;
         miscMeta <= {port12PinIn, port13PinIn, frontEndIrq, supplyFault, debugToolLine, primarySerialIn};
         miscSync <= miscMeta;
      end
   end

   assign {p12Sync, p13Sync, feIrqSync, faultSync, toolSync, serialSync} = miscSync;

   //---------------------------------------------------------------------------
   // bus decode
   //---------------------------------------------------------------------------
   assign wordIdx = adr_i[9:2];
   assign accFunc = gpp_func_e'(wordIdx[5:3]);
   assign accSlot = wordIdx[2:0];
   assign cfgArea = (wordIdx[7:6] == 2'h0);
   assign slotOk  = ({29'h0000_0000, accSlot} < NPORT);
   // a write lands on the edge where the master sees ack
   assign wrEn    = cyc_i && stb_i && we_i && ack_o && sel_i[0];
   assign rdStart = cyc_i && stb_i && !ack_o;

   //---------------------------------------------------------------------------
   // port configuration registers
   //---------------------------------------------------------------------------
   // each store is masked by the slot's capability, so absent bits read zero
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         for (int k = 0; k < NPORT; k++) begin
            dirReg[k]  <= `GPP_CFG_RST;
            outReg[k]  <= `GPP_CFG_RST;
            pullReg[k] <= `GPP_CFG_RST;
            ttlReg[k]  <= `GPP_CFG_RST;
            odReg[k]   <= `GPP_CFG_RST;
            anaReg[k]  <= gpp_byte_t'(`GPP_ANALOG_RST >> (k*8));
         end
      end else if (clockEn && wrEn && cfgArea && slotOk) begin
         unique case (accFunc)
            FN_DIR    : dirReg[accSlot]  <= dat_i[7:0] & capMask(FN_DIR, int'(accSlot));
            FN_OUT    : outReg[accSlot]  <= dat_i[7:0] & capMask(FN_OUT, int'(accSlot));
            FN_PULL   : pullReg[accSlot] <= dat_i[7:0] & capMask(FN_PULL, int'(accSlot));
            FN_TTL    : ttlReg[accSlot]  <= dat_i[7:0] & capMask(FN_TTL, int'(accSlot));
            FN_OD     : odReg[accSlot]   <= dat_i[7:0] & capMask(FN_OD, int'(accSlot));
            FN_ANALOG : anaReg[accSlot]  <= dat_i[7:0] & capMask(FN_ANALOG, int'(accSlot));
            FN_INPUT, FN_NONE : begin
               // read-only or unmapped: writes vanish
            end
         endcase
      end
   end

   // redirection register
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         redirReg <= `GPP_REDIR_RST;
      end else if (clockEn && wrEn && wordIdx == `GPP_IDX_REDIR) begin
         redirReg <= {7'h00, dat_i[`GPP_REDIR_SERIAL]};
      end
   end

   //---------------------------------------------------------------------------
   // pin drive
   //---------------------------------------------------------------------------
   // options are qualified by direction here, so software may preset them
   // while the bit still points the other way; outputs lag config by one cycle
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         portPinOut    <= '0;
         portPinOe_b   <= '1;
         portPullEn    <= '0;
         portTtlSel    <= '0;
         portAnalogSel <= '0;
      end else if (clockEn) begin
         for (int k = 0; k < NPORT; k++) begin
            for (int b = 0; b < 8; b++) begin
               logic isOut;
               logic isAna;
               logic odEff;
               isOut = dirReg[k][b] && !anaReg[k][b];
               // bridge clock is always driven toward the front end
               if (k == `GPP_BRIDGE_SLOT && b == `GPP_BRIDGE_CLK_BIT) begin
                  isOut = !anaReg[k][b];
               end
               isAna = anaReg[k][b];
               odEff = odReg[k][b] && isOut;
               // open drain never drives high, it only releases
               portPinOut[k][b]    <= outReg[k][b] && !odEff;
               portPinOe_b[k][b]   <= !(isOut && (!odEff || !outReg[k][b]));
               portPullEn[k][b]    <= pullReg[k][b] && !isOut && !isAna;
               portTtlSel[k][b]    <= ttlReg[k][b] && !isOut && !isAna;
               portAnalogSel[k][b] <= isAna;
            end
         end
      end
   end

   // serial input follows the redirect selection
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         serialIn <= 1'b1;
      end else if (clockEn) begin
         serialIn <= redirReg[`GPP_REDIR_SERIAL] ? pinSync[`GPP_REDIR_SLOT][`GPP_REDIR_BIT]
                                                 : serialSync;
      end
   end

   //---------------------------------------------------------------------------
   // interrupts
   //---------------------------------------------------------------------------
   // front-end requests arrive on internal wires, never from a pin
   assign irqLevel = {p13Sync, feIrqSync};
   assign irqEvt   = irqLevel & ~irqPrev;

   // sticky status: an edge in the same cycle as its clear wins
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         irqStat <= '0;
         irqPrev <= '1;
      end else if (clockEn) begin
         irqPrev <= irqLevel;
         if (wrEn && wordIdx == `GPP_IDX_IRQ_CLR) begin
            irqStat <= (irqStat & ~dat_i[`GPP_IRQ_W-1:0]) | irqEvt;
         end else begin
            irqStat <= irqStat | irqEvt;
         end
      end
   end

   // enable register
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         irqEn <= '0;
      end else if (clockEn && wrEn && wordIdx == `GPP_IDX_IRQ_EN) begin
         irqEn <= dat_i[`GPP_IRQ_W-1:0];
      end
   end

   // interrupt line, registered
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else if (clockEn) begin
         irq <= |(irqStat & irqEn);
      end
   end

   //---------------------------------------------------------------------------
   // reset output and mode select
   //---------------------------------------------------------------------------
   // front-end reset held low during system reset and while the supply is bad
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         frontEndResetOut_b <= 1'b0;
      end else if (clockEn) begin
         frontEndResetOut_b <= !faultSync;
      end
   end

   // the mode line is taken once, on the first enabled edge after release;
   // later changes of the line are ignored until the next reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         modeState  <= MODE_WAIT;
         normalMode <= 1'b0;
      end else if (clockEn) begin
         unique case (modeState)
            MODE_WAIT : begin
               normalMode <= toolSync;
               modeState  <= MODE_DONE;
            end
            MODE_DONE : begin
               modeState  <= MODE_DONE;
            end
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // read mux
   //---------------------------------------------------------------------------
   // unmapped words and write-only registers read zero
   always_comb begin
      next_datO = 32'h0000_0000;
      if (cfgArea && slotOk) begin
         unique case (accFunc)
            FN_DIR    : next_datO[7:0] = dirReg[accSlot];
            FN_OUT    : next_datO[7:0] = outReg[accSlot];
            FN_PULL   : next_datO[7:0] = pullReg[accSlot];
            FN_TTL    : next_datO[7:0] = ttlReg[accSlot];
            FN_OD     : next_datO[7:0] = odReg[accSlot];
            FN_ANALOG : next_datO[7:0] = anaReg[accSlot];
            // analog bits read zero in the digital path
            FN_INPUT  : next_datO[7:0] = pinSync[accSlot] & capMask(FN_INPUT, int'(accSlot)) & ~anaReg[accSlot];
            FN_NONE   : next_datO[7:0] = 8'h00;
         endcase
      end else if (wordIdx == `GPP_IDX_REDIR) begin
         next_datO[7:0] = redirReg;
      end else if (wordIdx == `GPP_IDX_IRQ_STAT) begin
         next_datO[`GPP_IRQ_W-1:0] = irqStat;
      end else if (wordIdx == `GPP_IDX_IRQ_EN) begin
         next_datO[`GPP_IRQ_W-1:0] = irqEn;
      end else if (wordIdx == `GPP_IDX_MODE) begin
         next_datO[0] = normalMode;
      end else if (wordIdx == `GPP_IDX_INONLY) begin
         next_datO[2:0]              = p12Sync;
         next_datO[`GPP_INONLY_P13]  = p13Sync;
      end
   end

   //---------------------------------------------------------------------------
   // wishbone handshake
   //---------------------------------------------------------------------------
   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else if (clockEn) begin
         ack_o <= rdStart;
         if (rdStart && !we_i) begin
            dat_o <= next_datO;
         end
      end
   end

endmodule // gpp_port_ctrl

/* verification/gpp_port_ctrl_assertions.sv */
// concurrent checks on the port pin control ports
`timescale 1ns/1ps
module gpp_port_ctrl_assertions #(
   parameter int NPORT = 7                               // port slots
) (
   input wire logic                  clock,              // core clock
   input wire logic                  rst_b,              // sync reset, low active
   input wire logic                  cyc_i,              // bus cycle
   input wire logic                  stb_i,              // bus strobe
   input wire logic                  ack_o,              // bus acknowledge
   input wire logic [NPORT-1:0][7:0] portPinOe_b,        // low drives the pin
   input wire logic [NPORT-1:0][7:0] portPullEn,         // pull-up enables
   input wire logic [NPORT-1:0][7:0] portTtlSel,         // ttl selects
   input wire logic [NPORT-1:0][7:0] portAnalogSel,      // analog selects
   input wire logic                  frontEndResetOut_b, // front-end reset out
   input wire logic                  normalMode          // chosen mode
);
   //---------------------------------------------
   // port relations
   //---------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // a request the slave has not answered yet
   sequence s_take; cyc_i && stb_i && !ack_o; endsequence
   property p_reqAck; s_take |=> ack_o ##1 !ack_o; endproperty
   a_reqAck: assert property (p_reqAck) else $error("request not acked once");
   // reset checks must run while reset is low, so they switch the default disable off
   property p_reset; disable iff (1'b0) !rst_b |=> (&portPinOe_b) && portPullEn == '0 && portAnalogSel == '0; endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   property p_feRst; disable iff (1'b0) !rst_b |=> !frontEndResetOut_b; endproperty
   a_feRst: assert property (p_feRst) else $error("front-end reset not low");
   property p_anaRise; $rose(rst_b) |=> portAnalogSel[2][3:0] == 4'hF; endproperty
   a_anaRise: assert property (p_anaRise) else $error("port 2 not analog");
   // input-side options never sit on a driven pin
   property p_cfgIn; ((portPullEn | portTtlSel | portAnalogSel) & ~portPinOe_b) == '0; endproperty
   a_cfgIn: assert property (p_cfgIn) else $error("input option on driven pin");
   property p_absent; &portPinOe_b[2][7:4] && &portPinOe_b[5][7:4] && portTtlSel[1][7:5] == 3'h0; endproperty
   a_absent: assert property (p_absent) else $error("absent bit active");
   property p_bridge; $past(rst_b) |-> !portPinOe_b[6][3]; endproperty
   a_bridge: assert property (p_bridge) else $error("bridge clock not driven");
   property p_mode; $past(rst_b, 2) && $past(rst_b) |-> $stable(normalMode); endproperty
   a_mode: assert property (p_mode) else $error("mode changed after release");
endmodule // gpp_port_ctrl_assertions

/* verification/gpp_pin_board.sv */
// board side of the port pins: far-end levels and pull-ups
`timescale 1ns/1ps
module gpp_pin_board #(
   parameter int NPORT = 7                     // port slots
) (
   input wire logic [NPORT-1:0][7:0] pinOut,   // level the block drives
   input wire logic [NPORT-1:0][7:0] pinOe_b,  // low where the block drives
   input wire logic [NPORT-1:0][7:0] pullEn,   // on-chip pull-up enables
   input wire logic [NPORT-1:0][7:0] farLevel, // far circuit level
   output     logic [NPORT-1:0][7:0] pinIn     // resolved pin level
);
   // a released pin with pull-up reads high, a released open drain shows the far level
   assign pinIn = (~pinOe_b & pinOut) | (pinOe_b & (pullEn | farLevel));
endmodule // gpp_pin_board

/* verification/gpp_port_ctrl_tb.sv */
// self-checking bench for the port pin control block
`timescale 1ns/1ps
`include "gpp_regs.svh"
`define CHK(NM, EXP, GOT) begin compares++; if ((GOT) !== (EXP)) begin bad_count++; \
   $display("wrong value %s exp %h got %h", NM, EXP, GOT); end end
module gpp_port_ctrl_tb;
   import gpp_pkg::*;
   localparam int NP = `GPP_NPORT;                                   // port slots
   logic               clock = 0, rst_b = 0, cyc = 0, stb = 0, we = 0; // clock, reset, bus
   logic [9:0]         adr = 0;                                      // bus address
   gpp_word_t          wDat = 0, rd, rDat;                           // bus data
   logic               ack, irq, feRst_b, nMode, serIn;              // design outputs
   logic               p13 = 0, sFault = 0, dbg = 1, pSer = 0;       // pin inputs
   logic [2:0]         p12 = 0;                                      // input-only port
   logic [5:0]         feIrq = 0;                                    // front-end requests
   logic [NP-1:0][7:0] pinIn, pinOut, oeB, pull, ttl, an, far = 0;   // pin side
   logic [7:0]         rnd = 8'h3B, v[6];                            // random source, config
   int                 k, bad_count = 0, compares = 0;               // counters
   //---------------------------------------------
   // design, board and clock
   //---------------------------------------------
   always #25 clock = ~clock;
   gpp_port_ctrl gpp_port_ctrl_inst (.clock(clock), .rst_b(rst_b), .clockEn(1'b1), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .dat_i(wDat), .sel_i(4'h1), .dat_o(rDat), .ack_o(ack), .portPinIn(pinIn),
      .portPinOut(pinOut), .portPinOe_b(oeB), .portPullEn(pull), .portTtlSel(ttl), .portAnalogSel(an),
      .port12PinIn(p12), .port13PinIn(p13), .frontEndIrq(feIrq), .supplyFault(sFault),
      .frontEndResetOut_b(feRst_b), .debugToolLine(dbg), .normalMode(nMode), .primarySerialIn(pSer),
      .serialIn(serIn), .irq(irq));
   gpp_pin_board #(.NPORT(NP)) gpp_pin_board_inst (.pinOut(pinOut), .pinOe_b(oeB), .pullEn(pull),
      .farLevel(far), .pinIn(pinIn));
   //---------------------------------------------
   // helpers
   //---------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] msk(input logic [63:0] m, input int s);
      return m[8*s +: 8];
   endfunction
   task automatic complete_run();
      $display("errors %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // one classic cycle; holds everything until ack is seen, a silent slave ends the run
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'h0};
      wDat <= {24'h00_0000, d};
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = rDat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) bad_count++;
      if (ack !== 1'b1) complete_run();
      @(posedge clock);
   endtask
   task automatic waitIrq();
      for (int n = 0; n < 20 && irq !== 1'b1; n++) @(posedge clock);
      `CHK("irq", 1'b1, irq)
      if (irq !== 1'b1) complete_run();
   endtask
   // expected pin side of one slot from the six values just written
   task automatic chkSlot(input int s);
      logic [7:0] a, dr, drv, inp;
      a = v[5] & msk(`GPP_ANALOG_MASK, s);
      dr = v[0] & msk(`GPP_WIDTH_MASK, s) & ~a;
      drv = (dr & ~(v[4] & msk(`GPP_OD_MASK, s) & v[1])) | ((s == 6) ? 8'h08 & ~a : 8'h00);
      inp = ~dr & ~a & ((s == 6) ? 8'hF7 : 8'hFF);
      `CHK("oe", ~drv, oeB[s])
      `CHK("out", v[1] & drv, pinOut[s] & drv)
      `CHK("pull", v[2] & msk(`GPP_PULL_MASK, s) & inp, pull[s])
      `CHK("ttl", v[3] & msk(`GPP_TTL_MASK, s) & inp, ttl[s])
      `CHK("ana", a, an[s])
   endtask
   //---------------------------------------------
   // main sequence
   //---------------------------------------------
   initial begin
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      repeat (2) @(posedge clock);
      `CHK("mode", 1'b1, nMode)
      `CHK("feRst", 1'b1, feRst_b)
      `CHK("oe0", 8'hFF, oeB[0])
      wb(1'b0, 8'h2A, 8'h00);
      `CHK("ana2", 32'h0000_000F, rd)
      far <= {NP{8'hA5}};
      repeat (4) @(posedge clock);
      wb(1'b0, 8'h30, 8'h00);
      `CHK("in0", 32'h0000_00A5, rd)
      // random configurations, every slot three times
      for (k = 0; k < 3 * NP; k++) begin
         for (int f = 0; f < 6; f++) begin
            rnd = lfsr(rnd);
            v[f] = rnd;
            wb(1'b1, 8'(f * 8 + k % NP), rnd);
         end
         repeat (2) @(posedge clock);
         chkSlot(k % NP);
      end
      p12 <= rnd[2:0];
      repeat (4) @(posedge clock);
      wb(1'b0, 8'h45, 8'h00);
      `CHK("inOnly", 32'(rnd[2:0]), rd)
      // port 13 edge, then a masked front-end request
      wb(1'b1, 8'h42, 8'h40);
      p13 <= 1'b1;
      waitIrq();
      wb(1'b1, 8'h43, 8'h40);
      feIrq <= 6'h01;
      repeat (6) @(posedge clock);
      `CHK("irqMask", 1'b0, irq)
      wb(1'b0, 8'h41, 8'h00);
      `CHK("stat", 32'h0000_0001, rd)
      wb(1'b1, 8'h42, 8'h01);
      waitIrq();
      // serial input follows the redirected pin
      wb(1'b1, 8'h05, 8'h04);
      wb(1'b1, 8'h06, 8'h04);
      wb(1'b1, 8'h40, 8'h01);
      for (k = 0; k < 2; k++) begin
         far[5][3] <= k[0];
         pSer <= ~k[0];
         repeat (4) @(posedge clock);
         `CHK("ser", k[0], serIn)
      end
      sFault <= 1'b1;
      repeat (4) @(posedge clock);
      `CHK("feRstLow", 1'b0, feRst_b)
      complete_run();
   end
endmodule // gpp_port_ctrl_tb
bind gpp_port_ctrl gpp_port_ctrl_assertions #(.NPORT(NPORT)) gpp_port_ctrl_assertions_inst (.clock(clock),
   .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .portPinOe_b(portPinOe_b),
   .portPullEn(portPullEn), .portTtlSel(portTtlSel), .portAnalogSel(portAnalogSel),
   .frontEndResetOut_b(frontEndResetOut_b), .normalMode(normalMode));
